// ---- verilog/dfm_pkg.sv ----
`default_nettype none

package dfm_pkg;

  // fault classes, ordered like the bits of the mask register
  localparam int DFM_NCLS = 5;
  localparam int CLS_OVERLOAD = 0;
  localparam int CLS_OVERCUR = 1;
  localparam int CLS_OW_OFF = 2;
  localparam int CLS_OW_ON = 3;
  localparam int CLS_SHORT = 4;

  // classes that the chain strap switches off (overload survives it)
  localparam logic [4:0] STRAP_KILL = 5'h1E;

  // register indices; byte address is four times the index
  localparam logic [5:0] IDX_MASK = 6'h0F;
  localparam logic [5:0] IDX_SHORT_EN = 6'h10;
  localparam logic [5:0] IDX_OW_ON_EN = 6'h11;
  localparam logic [5:0] IDX_OW_OFF_EN = 6'h12;
  localparam logic [5:0] IDX_FLAG0 = 6'h13;
  localparam logic [5:0] IDX_LIVE = 6'h18;

  // reset values
  localparam logic [7:0] MASK_RST = 8'hBE;
  localparam logic [7:0] EN_RST = 8'h00;

  // axi4-lite responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    WR_IDLE = 2'h1,
    WR_RESP = 2'h2
  } dfm_wr_t;

  typedef enum logic [1:0] {
    RD_IDLE = 2'h1,
    RD_RESP = 2'h2
  } dfm_rd_t;

endpackage

`default_nettype wire

// ---- verilog/dfm_fault_if.sv ----
`default_nettype none

// carries raw faults and settings to the qualifier and its results back
interface dfm_fault_if #(
  parameter int NUM_CH = 8
);
  logic [4:0][NUM_CH-1:0] raw;
  logic [4:0][NUM_CH-1:0] enable;
  logic [4:0][NUM_CH-1:0] flag;
  logic [4:0] mask;
  logic strap;
  logic [4:0] pin_cls;
  logic pin_req;

  modport qual (
    input raw, enable, mask, strap,
    output flag, pin_cls, pin_req
  );
  modport ctrl (
    output raw, enable, mask, strap,
    input flag, pin_cls, pin_req
  );
endinterface

`default_nettype wire

// ---- verilog/dfm_fault_qual.sv ----
`default_nettype none

module dfm_fault_qual
  import dfm_pkg::*;
#(
  parameter int NUM_CH = 8
) (
  // qualifier side of the fault carrier
  dfm_fault_if.qual f
);

  ////////////////////////////////////////////////////////////////////////
  // per class qualification
  genvar c;
  generate
    for (c = 0; c < DFM_NCLS; c++)
    begin : g_cls
      // strap kills detection outright, so no enable can revive it
      wire kill = f.strap & STRAP_KILL[c];
      // status ignores the mask entirely
      assign f.flag[c] = f.raw[c] & f.enable[c] & {NUM_CH{~kill}};
      // a set mask bit keeps the class off the pin
      assign f.pin_cls[c] = (|f.flag[c]) & ~f.mask[c];
    end
  endgenerate

  // any unmasked class on any channel requests the pin
  assign f.pin_req = |f.pin_cls;

endmodule

`default_nettype wire

// ---- verilog/dfm_top.sv ----
// Operation
// - short-to-supply mask set keeps short faults off the fault pin.
// - enabled short detection still shows in status and serial flags.
// - chain strap high disables short detection on all channels.
// - open-wire-on mask set keeps those faults off the fault pin.
// - enabled open-wire-on detection still reported in status and serial.
// - chain strap high disables open-wire-on detection everywhere.
// - open-wire-off mask set keeps those faults off the fault pin.
// - enabled open-wire-off detection still reported in status and serial.
// - chain strap high disables open-wire-off detection everywhere.
// - over-current mask set keeps over-current off the fault pin.
// - over-current reported in status and serial data whenever chain strap is low.
// - chain strap high means over-current is never signalled.
// - overload mask set keeps overload faults off the fault pin.
// - overload always reported in status and serial overload flag.
// - per-channel short enable bit turns short detection on or off.
//
// Added by the designer: the placing of the registers and register access over AXI4-Lite.
`default_nettype none

module dfm_top
  import dfm_pkg::*;
#(
  parameter int NUM_CH = 8,
  parameter int ADDR_W = 8
) (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_rst,
  // strap and raw per-channel diagnostics
  input wire logic i_chain_strap,
  input wire logic [NUM_CH-1:0] i_short_raw,
  input wire logic [NUM_CH-1:0] i_ow_on_raw,
  input wire logic [NUM_CH-1:0] i_ow_off_raw,
  input wire logic [NUM_CH-1:0] i_overcurrent_raw,
  input wire logic [NUM_CH-1:0] i_overload_raw,
  // axi4-lite write address and data
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [ADDR_W-1:0] i_awaddr,
  input wire logic i_wvalid,
  output logic o_wready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  // axi4-lite write response
  output logic o_bvalid,
  input wire logic i_bready,
  output logic [1:0] o_bresp,
  // axi4-lite read
  input wire logic i_arvalid,
  output logic o_arready,
  input wire logic [ADDR_W-1:0] i_araddr,
  output logic o_rvalid,
  input wire logic i_rready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  // fault pin and serial summary flags
  output logic o_fault_n,
  output logic [4:0] o_serial_flags
);

  ////////////////////////////////////////////////////////////////////////
  // elaboration checks
  generate
    if (NUM_CH < 1 || NUM_CH > 32)
    begin : g_bad_ch
      $error("NUM_CH must lie between 1 and 32");
    end
    // the decoders take the word index from address bits 7:2
    if (ADDR_W < 8 || ADDR_W > 32)
    begin : g_bad_aw
      $error("ADDR_W must lie between 8 and 32");
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // declarations
  dfm_fault_if #(.NUM_CH(NUM_CH)) fif ();

  logic [7:0] mask_r;
  logic [NUM_CH-1:0] short_en_r;
  logic [NUM_CH-1:0] ow_on_en_r;
  logic [NUM_CH-1:0] ow_off_en_r;
  logic [4:0][NUM_CH-1:0] flag_r;
  logic fault_n_r;
  logic [4:0] serial_r;

  dfm_wr_t wr_st_r;
  dfm_rd_t rd_st_r;
  logic aw_got_r;
  logic w_got_r;
  logic awready_r;
  logic wready_r;
  logic [5:0] wr_idx_r;
  logic [31:0] wdata_r;
  logic wlane0_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic arready_r;
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;

  logic [31:0] rd_data;
  logic rd_hit;

  ////////////////////////////////////////////////////////////////////////
  // fault qualifier
  dfm_fault_qual #(.NUM_CH(NUM_CH)) u_qual (
    .f(fif.qual)
  );

  // drive the carrier; overload and over-current have no enable of
  // their own, so their enable is tied on
  assign fif.raw[CLS_OVERLOAD] = i_overload_raw;
  assign fif.raw[CLS_OVERCUR] = i_overcurrent_raw;
  assign fif.raw[CLS_OW_OFF] = i_ow_off_raw;
  assign fif.raw[CLS_OW_ON] = i_ow_on_raw;
  assign fif.raw[CLS_SHORT] = i_short_raw;
  assign fif.enable[CLS_OVERLOAD] = {NUM_CH{1'b1}};
  assign fif.enable[CLS_OVERCUR] = {NUM_CH{1'b1}};
  assign fif.enable[CLS_OW_OFF] = ow_off_en_r;
  assign fif.enable[CLS_OW_ON] = ow_on_en_r;
  assign fif.enable[CLS_SHORT] = short_en_r;
  assign fif.mask = mask_r[4:0];
  assign fif.strap = i_chain_strap;

  ////////////////////////////////////////////////////////////////////////
  // write channel decode
  wire wr_fire = aw_got_r & w_got_r & (wr_st_r == WR_IDLE);
  wire wr_mask = wr_idx_r == IDX_MASK;
  wire wr_sen = wr_idx_r == IDX_SHORT_EN;
  wire wr_onen = wr_idx_r == IDX_OW_ON_EN;
  wire wr_offen = wr_idx_r == IDX_OW_OFF_EN;
  wire wr_flag = (wr_idx_r >= IDX_FLAG0) &&
                 (wr_idx_r < IDX_FLAG0 + 6'(DFM_NCLS));
  // the live register is read only; writing it is an error
  wire wr_hit = wr_mask | wr_sen | wr_onen | wr_offen | wr_flag;
  wire wr_do = wr_fire & wlane0_r;
  wire [7:0] wbyte = wdata_r[7:0];

  // write handshake: address and data are taken in either order and the
  // response issues once both are held
  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
    begin
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      awready_r <= 1'b1;
      wready_r <= 1'b1;
      wr_idx_r <= 6'h00;
      wdata_r <= 32'h0000_0000;
      wlane0_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
      wr_st_r <= WR_IDLE;
    end
    else
    begin
      case (wr_st_r)
        WR_IDLE:
        begin
          if (i_awvalid && awready_r)
          begin
            aw_got_r <= 1'b1;
            awready_r <= 1'b0;
            wr_idx_r <= i_awaddr[7:2];
          end
          if (i_wvalid && wready_r)
          begin
            w_got_r <= 1'b1;
            wready_r <= 1'b0;
            wdata_r <= i_wdata;
            wlane0_r <= i_wstrb[0];
          end
          if (wr_fire)
          begin
            bvalid_r <= 1'b1;
            bresp_r <= wr_hit ? RESP_OKAY : RESP_SLVERR;
            wr_st_r <= WR_RESP;
          end
        end
        WR_RESP:
        begin
          if (i_bready)
          begin
            bvalid_r <= 1'b0;
            aw_got_r <= 1'b0;
            w_got_r <= 1'b0;
            awready_r <= 1'b1;
            wready_r <= 1'b1;
            wr_st_r <= WR_IDLE;
          end
        end
        default:
        begin
          wr_st_r <= WR_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // control registers; a write needs byte lane 0 strobed, and the mask takes lane 0 only
  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
    begin
      mask_r <= MASK_RST;
      short_en_r <= NUM_CH'(EN_RST);
      ow_on_en_r <= NUM_CH'(EN_RST);
      ow_off_en_r <= NUM_CH'(EN_RST);
    end
    else if (wr_do)
    begin
      if (wr_mask)
        mask_r <= wbyte;
      if (wr_sen)
        short_en_r <= NUM_CH'(wdata_r);
      if (wr_onen)
        ow_on_en_r <= NUM_CH'(wdata_r);
      if (wr_offen)
        ow_off_en_r <= NUM_CH'(wdata_r);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // sticky status flags, write one to clear; a fault present in the
  // clearing cycle re-sets the bit so no event is lost
  genvar c;
  generate
    for (c = 0; c < DFM_NCLS; c++)
    begin : g_flag
      localparam logic [5:0] MY_IDX = IDX_FLAG0 + 6'(c);
      wire hit = wr_do & (wr_idx_r == MY_IDX);
      wire [NUM_CH-1:0] clr = hit ? NUM_CH'(wdata_r) : '0;
      always_ff @(posedge i_mclk or posedge i_rst)
      begin
        if (i_rst)
          flag_r[c] <= '0;
        else
          flag_r[c] <= (flag_r[c] & ~clr) | fif.flag[c];
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // pin and serial summary; registered so the pin cannot glitch on
  // combinational hazards in the qualifier
  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
    begin
      fault_n_r <= 1'b1;
      serial_r <= 5'h00;
    end
    else
    begin
      fault_n_r <= ~fif.pin_req;
      for (int k = 0; k < DFM_NCLS; k++)
        serial_r[k] <= |fif.flag[k];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read decode; narrow registers sit in the low bits
  wire [5:0] rd_idx = i_araddr[7:2];
  wire [2:0] rd_cls = 3'(rd_idx - IDX_FLAG0);
  wire [7:0] live_byte = {2'h0, fif.pin_req, fif.pin_cls};

  always_comb
  begin
    rd_data = 32'h0000_0000;
    rd_hit = 1'b1;
    if (rd_idx == IDX_MASK)
      rd_data = 32'(mask_r);
    else if (rd_idx == IDX_SHORT_EN)
      rd_data = 32'(short_en_r);
    else if (rd_idx == IDX_OW_ON_EN)
      rd_data = 32'(ow_on_en_r);
    else if (rd_idx == IDX_OW_OFF_EN)
      rd_data = 32'(ow_off_en_r);
    else if (rd_idx >= IDX_FLAG0 && rd_idx < IDX_FLAG0 + 6'(DFM_NCLS))
      rd_data = 32'(flag_r[rd_cls]);
    else if (rd_idx == IDX_LIVE)
      rd_data = 32'(live_byte);
    else
      rd_hit = 1'b0;
  end

  // read handshake: data is captured when the address is taken
  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
    begin
      arready_r <= 1'b1;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= RESP_OKAY;
      rd_st_r <= RD_IDLE;
    end
    else
    begin
      case (rd_st_r)
        RD_IDLE:
        begin
          if (i_arvalid)
          begin
            arready_r <= 1'b0;
            rvalid_r <= 1'b1;
            rdata_r <= rd_data;
            rresp_r <= rd_hit ? RESP_OKAY : RESP_SLVERR;
            rd_st_r <= RD_RESP;
          end
        end
        RD_RESP:
        begin
          if (i_rready)
          begin
            rvalid_r <= 1'b0;
            arready_r <= 1'b1;
            rd_st_r <= RD_IDLE;
          end
        end
        default:
        begin
          rd_st_r <= RD_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs, all straight from flip-flops
  assign o_awready = awready_r;
  assign o_wready = wready_r;
  assign o_bvalid = bvalid_r;
  assign o_bresp = bresp_r;
  assign o_arready = arready_r;
  assign o_rvalid = rvalid_r;
  assign o_rdata = rdata_r;
  assign o_rresp = rresp_r;
  assign o_fault_n = fault_n_r;
  assign o_serial_flags = serial_r;

endmodule

`default_nettype wire

// ---- test/dfm_chk_asserts.sv ----
`default_nettype none

module dfm_chk #(
  parameter int NUM_CH = 8
) (
  // clock, reset and strap
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_chain_strap,
  // raw diagnostics
  input wire logic [NUM_CH-1:0] i_short_raw,
  input wire logic [NUM_CH-1:0] i_ow_on_raw,
  input wire logic [NUM_CH-1:0] i_ow_off_raw,
  input wire logic [NUM_CH-1:0] i_overcurrent_raw,
  input wire logic [NUM_CH-1:0] i_overload_raw,
  // bus handshakes
  input wire logic i_arvalid,
  input wire logic o_arready,
  input wire logic o_rvalid,
  input wire logic o_awready,
  input wire logic o_bvalid,
  input wire logic i_bready,
  input wire logic [1:0] o_bresp,
  // fault outputs
  input wire logic o_fault_n,
  input wire logic [4:0] o_serial_flags
);
  timeunit 1ns;
  timeprecision 1ps;

  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (i_rst);

  ////////////////////////////////////////////////////////////////////////////
  // fault path: flags trail the raw inputs by one edge, mask plays no part
  ovld_flag_a: assert property (!$past(i_rst) |->
    o_serial_flags[0] == $past(|i_overload_raw))
    else $error("overload flag off its raw input");
  strap_kill_a: assert property (
    !$past(i_rst) && $past(i_chain_strap) |-> o_serial_flags[4:1] == 4'h0)
    else $error("strap did not silence classes");
  ocur_flag_a: assert property (
    !$past(i_rst) && !$past(i_chain_strap) |->
    o_serial_flags[1] == $past(|i_overcurrent_raw))
    else $error("overcurrent flag off its raw input");
  flag_src_a: assert property (!$past(i_rst) |->
    (o_serial_flags[4:2] & ~{$past(|i_short_raw), $past(|i_ow_on_raw),
    $past(|i_ow_off_raw)}) == 3'h0)
    else $error("detect flag without raw fault");
  pin_cause_a: assert property (!o_fault_n |->
    o_serial_flags != 5'h00)
    else $error("fault pin low with no fault");

  ////////////////////////////////////////////////////////////////////////////
  // bus: one transfer at a time, answers held until taken
  wr_busy_a: assert property (o_bvalid |-> !o_awready)
    else $error("write address open during response");
  bresp_hold_a: assert property (o_bvalid && !i_bready |=>
    o_bvalid && $stable(o_bresp))
    else $error("write response dropped");
  rd_lat_a: assert property (i_arvalid && o_arready |=> o_rvalid)
    else $error("read data late");

  // main scenarios reached
  pin_low_c: cover property (!o_fault_n);
  short_c: cover property (o_serial_flags[4]);
  strap_c: cover property (i_chain_strap && !o_fault_n);
endmodule

`default_nettype wire

// ---- test/dfm_host.sv ----
`default_nettype none

module dfm_host (
  // clock
  input wire logic i_mclk,
  // write channels
  output logic o_awvalid,
  input wire logic i_awready,
  output logic [7:0] o_awaddr,
  output logic o_wvalid,
  input wire logic i_wready,
  output logic [31:0] o_wdata,
  output logic [3:0] o_wstrb,
  input wire logic i_bvalid,
  output logic o_bready,
  input wire logic [1:0] i_bresp,
  // read channels
  output logic o_arvalid,
  input wire logic i_arready,
  output logic [7:0] o_araddr,
  input wire logic i_rvalid,
  output logic o_rready,
  input wire logic [31:0] i_rdata,
  input wire logic [1:0] i_rresp
);
  timeunit 1ns;
  timeprecision 1ps;

  // idle bus from time zero
  initial
  begin
    {o_awvalid, o_wvalid, o_bready, o_arvalid, o_rready} = 5'h00;
    {o_awaddr, o_araddr, o_wdata, o_wstrb} = 52'h0;
  end

  // a stuck slave ends the run rather than hanging it
  task automatic hang();
    tb_top.n_errors++;
    tb_top.tally_and_finish();
  endtask

  // address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
    output logic [1:0] r);
    int n;
    n = 0;
    @(posedge i_mclk);
    o_awvalid <= 1'b1;
    o_awaddr <= a;
    o_wvalid <= 1'b1;
    o_wdata <= d;
    o_wstrb <= 4'hF;
    o_bready <= 1'b1;
    do
    begin
      @(posedge i_mclk);
      n++;
      if (i_awready) o_awvalid <= 1'b0;
      if (i_wready) o_wvalid <= 1'b0;
    end
    while (!i_bvalid && n < 50);
    o_bready <= 1'b0;
    r = i_bresp;
    if (!i_bvalid) hang();
  endtask

  // rready held from the start, data taken at the rvalid edge
  task automatic rd(input logic [7:0] a, output logic [31:0] d,
    output logic [1:0] r);
    int n;
    n = 0;
    @(posedge i_mclk);
    o_arvalid <= 1'b1;
    o_araddr <= a;
    o_rready <= 1'b1;
    do
    begin
      @(posedge i_mclk);
      n++;
      if (i_arready) o_arvalid <= 1'b0;
    end
    while (!i_rvalid && n < 50);
    o_rready <= 1'b0;
    d = i_rdata;
    r = i_rresp;
    if (!i_rvalid) hang();
  endtask
endmodule

`default_nettype wire

// ---- test/tb_top.sv ----
`default_nettype none

module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import dfm_pkg::*;

  logic i_mclk, i_rst, strap, fault_n;
  logic [4:0][7:0] raw;
  logic [4:0] sflags;
  logic awv, awr, wv, wr_rdy, bv, br, arv, arr, rv, rr;
  logic [7:0] awa, ara;
  logic [31:0] wd, rdat;
  logic [3:0] ws;
  logic [1:0] bresp, rresp;
  int n_errors = 0;
  int samples_checked = 0;

  ////////////////////////////////////////////////////////////////////////////
  dfm_top dfm_top_i (.i_mclk(i_mclk), .i_rst(i_rst), .i_chain_strap(strap),
    .i_short_raw(raw[CLS_SHORT]), .i_ow_on_raw(raw[CLS_OW_ON]),
    .i_ow_off_raw(raw[CLS_OW_OFF]), .i_overcurrent_raw(raw[CLS_OVERCUR]),
    .i_overload_raw(raw[CLS_OVERLOAD]), .i_awvalid(awv), .o_awready(awr),
    .i_awaddr(awa), .i_wvalid(wv), .o_wready(wr_rdy), .i_wdata(wd),
    .i_wstrb(ws), .o_bvalid(bv), .i_bready(br), .o_bresp(bresp),
    .i_arvalid(arv), .o_arready(arr), .i_araddr(ara), .o_rvalid(rv),
    .i_rready(rr), .o_rdata(rdat), .o_rresp(rresp), .o_fault_n(fault_n),
    .o_serial_flags(sflags));
  dfm_host dfm_host_i (.i_mclk(i_mclk), .o_awvalid(awv), .i_awready(awr),
    .o_awaddr(awa), .o_wvalid(wv), .i_wready(wr_rdy), .o_wdata(wd),
    .o_wstrb(ws), .i_bvalid(bv), .o_bready(br), .i_bresp(bresp),
    .o_arvalid(arv), .i_arready(arr), .o_araddr(ara), .i_rvalid(rv),
    .o_rready(rr), .i_rdata(rdat), .i_rresp(rresp));

  // 100 MHz clock
  initial
  begin
    i_mclk = 1'b0;
    forever #5 i_mclk = ~i_mclk;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish();
    if (n_errors == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      n_errors++;
      $display("mismatch %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
    input logic [1:0] er);
    logic [1:0] r;
    dfm_host_i.wr(a, d, r);
    cmp({30'h0, r}, {30'h0, er});
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp,
    input logic [1:0] er);
    logic [31:0] d;
    logic [1:0] r;
    dfm_host_i.rd(a, d, r);
    cmp(d, exp);
    cmp({30'h0, r}, {30'h0, er});
  endtask

  // three edges covers the one-edge fault path with margin
  task automatic drv(input logic [4:0][7:0] v, input logic s);
    @(posedge i_mclk);
    raw <= v;
    strap <= s;
    repeat (3) @(posedge i_mclk);
    #1;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    logic [4:0][7:0] v;
    i_rst = 1'b1;
    strap = 1'b0;
    raw = '0;
    repeat (2) @(posedge i_mclk);
    i_rst <= 1'b0;
    rd(8'h3C, 32'h000000BE, RESP_OKAY);
    rd(8'h40, 32'h0, RESP_OKAY);
    rd(8'h80, 32'h0, RESP_SLVERR);
    wr(8'h60, 32'h0, RESP_SLVERR);
    wr(8'h40, 32'hFF, RESP_OKAY);
    wr(8'h44, 32'hFF, RESP_OKAY);
    wr(8'h48, 32'hFF, RESP_OKAY);
    // each class masked then unmasked; sticky flag cleared after
    for (int c = 0; c < DFM_NCLS; c++)
    begin
      for (int m = 1; m >= 0; m--)
      begin
        wr(8'h3C, m ? 32'(1 << c) : 32'h0, RESP_OKAY);
        v = '0;
        v[c] = 8'h81;
        drv(v, 1'b0);
        cmp({31'h0, fault_n}, 32'(m));
        cmp({27'h0, sflags}, 32'(1 << c));
        rd(8'h4C + 8'(4 * c), 32'h81, RESP_OKAY);
        drv('0, 1'b0);
        cmp({31'h0, fault_n}, 32'h1);
        wr(8'h4C + 8'(4 * c), 32'hFF, RESP_OKAY);
        rd(8'h4C + 8'(4 * c), 32'h0, RESP_OKAY);
      end
    end
    // strap up: only overload survives
    drv({5{8'hFF}}, 1'b1);
    cmp({27'h0, sflags}, 32'h01);
    cmp({31'h0, fault_n}, 32'h0);
    v = {5{8'hFF}};
    v[CLS_OVERLOAD] = 8'h00;
    drv(v, 1'b1);
    cmp({27'h0, sflags}, 32'h0);
    cmp({31'h0, fault_n}, 32'h1);
    // channel 3 short detect off, channel 4 on
    wr(8'h40, 32'hF7, RESP_OKAY);
    v = '0;
    v[CLS_SHORT] = 8'h08;
    drv(v, 1'b0);
    cmp({27'h0, sflags}, 32'h0);
    cmp({31'h0, fault_n}, 32'h1);
    v[CLS_SHORT] = 8'h10;
    drv(v, 1'b0);
    cmp({27'h0, sflags}, 32'h10);
    rd(8'h60, 32'h30, RESP_OKAY);
    tally_and_finish();
  end
endmodule

bind dfm_top dfm_chk #(.NUM_CH(NUM_CH)) dfm_chk_i (.i_mclk(i_mclk),
  .i_rst(i_rst), .i_chain_strap(i_chain_strap), .i_short_raw(i_short_raw),
  .i_ow_on_raw(i_ow_on_raw), .i_ow_off_raw(i_ow_off_raw),
  .i_overcurrent_raw(i_overcurrent_raw), .i_overload_raw(i_overload_raw),
  .i_arvalid(i_arvalid), .o_arready(o_arready), .o_rvalid(o_rvalid),
  .o_awready(o_awready), .o_bvalid(o_bvalid), .i_bready(i_bready),
  .o_bresp(o_bresp), .o_fault_n(o_fault_n),
  .o_serial_flags(o_serial_flags));

`default_nettype wire
